// >>> hdl/fws_poll_ctrl.sv
// Purpose: host-side status poller for a parallel flash, run from APB registers
// Assumes: APB slave with no wait cycles; flash pins driven by fws_bus_cycle
// Notes:   automatic reset command after a timing-limit failure
//
// Operation
// - read cycles may be paced by output strobe or chip select.
// - host reads status at the program address or an erasing sector.
// - host reads twice, compares bit 6; unchanged means done.
// - toggling with bit 5 high: recheck; still toggling means failure.
// - host restarts the check from the top after leaving the loop.
// - after a bit 5 failure host issues the reset command.
// - host may skip bit 3 if erases follow within 50 us.
// - host confirms acceptance, then checks bit 3 around extra erases.
// - reset command is one write of F0 to any address.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "fws_params.svh"
module fws_poll_ctrl
   import fws_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // flash pins
   output fws_pins_t        flash_pins,
   input  wire logic [7:0]  flash_dq_in,
   input  wire logic        ready_busy_out_n
);
   fws_poll_st_t st_ff, nxt_st;
   logic         pend_ff, nxt_pend;
   logic [7:0]   prev_ff, nxt_prev;
   logic [7:0]   data_ff, nxt_data;
   logic         ok_ff, nxt_ok;
   logic         fail_ff, nxt_fail;
   logic         win_ff, nxt_win;
   logic         winv_ff, nxt_winv;
   logic         sect_ff, nxt_sect;
   logic         stop_ff, nxt_stop;
   logic         pace_ff, nxt_pace;
   logic [20:0]  addr_ff, nxt_addr;
   logic [2:0]   rd_cnt_ff, nxt_rd_cnt;
   logic         pready_ff, pslverr_ff;
   logic [31:0]  prdata_ff;
   logic         rb1_ff, rb2_ff, rb3_ff, rb_ff;
   logic         wr_acc, cyc_idle, cyc_done, hold, tog;
   logic [7:0]   cyc_rdata;
   fws_cyc_req_t cyc_req;

   // the cycle engine that drives the flash pins
   fws_bus_cycle fws_bus_cycle_inst (
      .pclk      (pclk),
      .presetn   (presetn),
      .req_valid (pend_ff),
      .req       (cyc_req),
      .pace_ce   (pace_ff),
      .hold      (hold),
      .idle      (cyc_idle),
      .done      (cyc_done),
      .rdata     (cyc_rdata),
      .pins      (flash_pins),
      .dq_in     (flash_dq_in)
   );

   // every poll read and the reset write use the programmed address
   assign cyc_req.kind  = (st_ff == ST_RST) ? FWS_WR : FWS_RD;
   assign cyc_req.addr  = addr_ff;
   assign cyc_req.wdata = `FWS_CMD_RESET;
   assign hold   = (st_ff == ST_RD1) || (st_ff == ST_RDN) ||
                   (st_ff == ST_RDCHK) || (st_ff == ST_FINAL);
   assign wr_acc = psel && penable && pready_ff && pwrite;
   assign tog    = cyc_rdata[`FWS_DQ_TOGGLE] ^ prev_ff[`FWS_DQ_TOGGLE];
   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // ready/busy pin synchroniser; a level counts once the last two agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rb1_ff <= 1'b1;
         rb2_ff <= 1'b1;
         rb3_ff <= 1'b1;
         rb_ff  <= 1'b1;
      end else begin
         rb1_ff <= ready_busy_out_n;
         rb2_ff <= rb1_ff;
         rb3_ff <= rb2_ff;
         if (rb2_ff == rb3_ff) begin
            rb_ff <= rb3_ff;
         end
      end
   end

   // apb slave: answer in the first access cycle, registered read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end else begin
         pready_ff  <= psel && !penable;
         pslverr_ff <= psel && !penable && paddr != `FWS_REG_CTRL &&
                       paddr != `FWS_REG_ADDR && paddr != `FWS_REG_STATUS;
         prdata_ff  <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `FWS_REG_CTRL:   prdata_ff <= {30'h0, pace_ff, 1'b0};
               `FWS_REG_ADDR:   prdata_ff <= {11'h000, addr_ff};
               `FWS_REG_STATUS: prdata_ff <= {16'h0000, data_ff, 1'b0, winv_ff,
                                              rb_ff, sect_ff, win_ff, fail_ff,
                                              ok_ff, (st_ff != ST_IDLE)};
               default:         prdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // poll sequencer and register writes, next values
   always_comb begin
      nxt_st     = st_ff;
      nxt_pend   = pend_ff && !cyc_idle;
      nxt_prev   = prev_ff;
      nxt_data   = data_ff;
      nxt_ok     = ok_ff;
      nxt_fail   = fail_ff;
      nxt_win    = win_ff;
      nxt_winv   = winv_ff;
      nxt_sect   = sect_ff;
      nxt_stop   = stop_ff;
      nxt_pace   = pace_ff;
      nxt_addr   = addr_ff;
      nxt_rd_cnt = rd_cnt_ff;
      if (wr_acc && paddr == `FWS_REG_ADDR && st_ff == ST_IDLE) begin
         nxt_addr = pwdata[20:0];
      end
      if (wr_acc && paddr == `FWS_REG_CTRL) begin
         if (st_ff == ST_IDLE) begin
            nxt_pace = pwdata[`FWS_CTRL_PACE_CE];
         end
         if (pwdata[`FWS_CTRL_STOP] && st_ff != ST_IDLE) begin
            nxt_stop = 1'b1;
         end
      end
      if (cyc_done && st_ff != ST_RST && st_ff != ST_IDLE) begin
         nxt_prev   = cyc_rdata;
         nxt_rd_cnt = (rd_cnt_ff == 3'h7) ? rd_cnt_ff : rd_cnt_ff + 3'h1;
      end
      unique case (st_ff)
         ST_IDLE: begin
            nxt_stop = 1'b0;
            if (wr_acc && paddr == `FWS_REG_CTRL && pwdata[`FWS_CTRL_START]) begin
               // always from the top of the check
               nxt_st     = ST_RD1;
               nxt_pend   = 1'b1;
               nxt_rd_cnt = 3'h0;
               nxt_ok     = 1'b0;
               nxt_fail   = 1'b0;
            end else if (wr_acc && paddr == `FWS_REG_CTRL &&
                         pwdata[`FWS_CTRL_WINDOW]) begin
               nxt_st   = ST_WIN;
               nxt_pend = 1'b1;
               nxt_winv = 1'b0;
            end
         end
         ST_RD1: begin
            if (cyc_done) begin
               nxt_st   = ST_RDN;
               nxt_pend = 1'b1;
            end
         end
         ST_RDN: begin
            if (cyc_done) begin
               nxt_pend = 1'b1;
               nxt_sect = cyc_rdata[`FWS_DQ_SECT] ^ prev_ff[`FWS_DQ_SECT];
               if (!tog) begin
                  nxt_st = ST_FINAL;
               end else if (cyc_rdata[`FWS_DQ_LIMIT]) begin
                  nxt_st = ST_RDCHK;
               end else if (stop_ff) begin
                  nxt_st   = ST_IDLE;
                  nxt_pend = 1'b0;
               end
            end
         end
         ST_RDCHK: begin
            if (cyc_done) begin
               nxt_pend = 1'b1;
               nxt_st   = tog ? ST_RST : ST_FINAL;
            end
         end
         ST_FINAL: begin
            if (cyc_done) begin
               nxt_data = cyc_rdata;
               nxt_ok   = 1'b1;
               nxt_st   = ST_IDLE;
            end
         end
         ST_RST: begin
            if (cyc_done) begin
               nxt_fail = 1'b1;
               nxt_st   = ST_IDLE;
            end
         end
         ST_WIN: begin
            if (cyc_done) begin
               nxt_win  = cyc_rdata[`FWS_DQ_WINDOW];
               nxt_winv = 1'b1;
               nxt_data = cyc_rdata;
               nxt_st   = ST_IDLE;
            end
         end
      endcase
   end

   // poll sequencer and register writes, registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff     <= ST_IDLE;
         pend_ff   <= 1'b0;
         prev_ff   <= 8'h00;
         data_ff   <= 8'h00;
         ok_ff     <= 1'b0;
         fail_ff   <= 1'b0;
         win_ff    <= 1'b0;
         winv_ff   <= 1'b0;
         sect_ff   <= 1'b0;
         stop_ff   <= 1'b0;
         pace_ff   <= 1'b0;
         addr_ff   <= 21'h000000;
         rd_cnt_ff <= 3'h0;
      end else begin
         st_ff     <= nxt_st;
         pend_ff   <= nxt_pend;
         prev_ff   <= nxt_prev;
         data_ff   <= nxt_data;
         ok_ff     <= nxt_ok;
         fail_ff   <= nxt_fail;
         win_ff    <= nxt_win;
         winv_ff   <= nxt_winv;
         sect_ff   <= nxt_sect;
         stop_ff   <= nxt_stop;
         pace_ff   <= nxt_pace;
         addr_ff   <= nxt_addr;
         rd_cnt_ff <= nxt_rd_cnt;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_poll_done;
      cyc_done && (st_ff == ST_RDN);
   endsequence

   chk_poll_read_addr: assert property (
      (cyc_done && hold) |-> (flash_pins.addr == addr_ff))
      else $error("status read not at the poll address");
   chk_done_two_reads: assert property (
      $rose(ok_ff) |-> (rd_cnt_ff >= 3'h3))
      else $error("completion reported without two status reads and a final read");
   chk_stop_toggle_final: assert property (
      (s_poll_done ##0 !tog) |=> (st_ff == ST_FINAL) && pend_ff)
      else $error("steady toggle bit did not lead to the final read");
   chk_limit_recheck: assert property (
      (s_poll_done ##0 (tog && cyc_rdata[`FWS_DQ_LIMIT])) |=> (st_ff == ST_RDCHK))
      else $error("toggle with limit flag was not rechecked");
   chk_fail_after_reset: assert property (
      $rose(fail_ff) |-> ($past(st_ff) == ST_RST) && (rd_cnt_ff >= 3'h3))
      else $error("failure reported without recheck and reset command");
   chk_reset_byte: assert property (
      !flash_pins.we_n |-> flash_pins.dq_oe && (flash_pins.dq_out == `FWS_CMD_RESET))
      else $error("write strobe low without the reset byte driven");
   chk_restart_top: assert property (
      (st_ff == ST_IDLE && wr_acc && paddr == `FWS_REG_CTRL && pwdata[`FWS_CTRL_START])
      |=> (st_ff == ST_RD1) && (rd_cnt_ff == 3'h0) && !ok_ff && !fail_ff)
      else $error("poll did not restart from the first read");
   chk_window_capture: assert property (
      (cyc_done && st_ff == ST_WIN) |=> winv_ff && (win_ff == $past(cyc_rdata[3])))
      else $error("erase window flag not captured");
endmodule : fws_poll_ctrl
`default_nettype wire

// >>> hdl/fws_params.svh
// Purpose: constants of the flash status poller (offsets, fields, timing)
// Assumes: pclk at 250 MHz
// Notes:   counts are derived from the times by round-up
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH

// register offsets (byte addresses)
`define FWS_REG_CTRL      12'h000
`define FWS_REG_ADDR      12'h004
`define FWS_REG_STATUS    12'h008

// control fields
`define FWS_CTRL_START    0
`define FWS_CTRL_PACE_CE  1
`define FWS_CTRL_STOP     2
`define FWS_CTRL_WINDOW   3

// status fields
`define FWS_ST_BUSY       0
`define FWS_ST_DONE_OK    1
`define FWS_ST_FAIL       2
`define FWS_ST_WINDOW     3
`define FWS_ST_SECT_TOG   4
`define FWS_ST_READY      5
`define FWS_ST_WIN_VALID  6
`define FWS_ST_DATA_LSB   8

// status bit positions in the flash data byte
`define FWS_DQ_POLL       7
`define FWS_DQ_TOGGLE     6
`define FWS_DQ_LIMIT      5
`define FWS_DQ_WINDOW     3
`define FWS_DQ_SECT       2

// reset command byte
`define FWS_CMD_RESET     8'hF0

// timing
`define FWS_CLK_NS        4
`define FWS_ACC_NS        120
`define FWS_WP_NS         50
`define FWS_REC_NS        30
`define FWS_ACC_CYC       ((`FWS_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_WP_CYC        ((`FWS_WP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_REC_CYC       ((`FWS_REC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_SYNC_CYC      3

`endif

// >>> hdl/fws_pkg.sv
// Purpose: types of the flash status poller
// Assumes: nothing
// Notes:   pin group and cycle request travel as packed structs
package fws_pkg;
   typedef enum logic {FWS_RD, FWS_WR} fws_kind_t;

   typedef struct packed {
      fws_kind_t   kind;
      logic [20:0] addr;
      logic [7:0]  wdata;
   } fws_cyc_req_t;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        dq_oe;
      logic [7:0]  dq_out;
      logic [20:0] addr;
   } fws_pins_t;

   typedef enum {CY_IDLE, CY_RD, CY_CAP, CY_WR, CY_WH, CY_REC} fws_cyc_st_t;

   typedef enum {ST_IDLE, ST_RD1, ST_RDN, ST_RDCHK, ST_FINAL, ST_RST, ST_WIN} fws_poll_st_t;
endpackage : fws_pkg

// >>> hdl/fws_bus_cycle.sv
// Purpose: one read or write cycle on the flash pins
// Assumes: requests only while idle is high
// Notes:   read data passes three flip-flops and is taken when the last two agree
`timescale 1ns/1ns
`default_nettype none
`include "fws_params.svh"
module fws_bus_cycle
   import fws_pkg::*;
(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // request side
   input  wire logic         req_valid,
   input  wire fws_cyc_req_t req,
   input  wire logic         pace_ce,
   input  wire logic         hold,
   output logic              idle,
   output logic              done,
   output logic [7:0]        rdata,
   // flash pins
   output fws_pins_t         pins,
   input  wire logic [7:0]   dq_in
);
   fws_cyc_st_t st_ff, nxt_st;
   logic [5:0]  cnt_ff, nxt_cnt;
   fws_pins_t   pins_ff, nxt_pins;
   logic        done_ff, nxt_done;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic [7:0]  sync1_ff, sync2_ff, sync3_ff;

   assign idle  = (st_ff == CY_IDLE);
   assign done  = done_ff;
   assign rdata = rdata_ff;
   assign pins  = pins_ff;

   // data pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 8'h00;
         sync2_ff <= 8'h00;
         sync3_ff <= 8'h00;
      end else begin
         sync1_ff <= dq_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // cycle sequencer next state
   always_comb begin
      nxt_st    = st_ff;
      nxt_cnt   = cnt_ff + 6'h01;
      nxt_pins  = pins_ff;
      nxt_done  = 1'b0;
      nxt_rdata = rdata_ff;
      unique case (st_ff)
         CY_IDLE: begin
            nxt_cnt        = 6'h00;
            nxt_pins.we_n  = 1'b1;
            nxt_pins.dq_oe = 1'b0;
            // the strobe that does not pace stays low through a poll session
            nxt_pins.ce_n  = pace_ce ? 1'b1 : !hold;
            nxt_pins.oe_n  = pace_ce ? !hold : 1'b1;
            if (req_valid) begin
               nxt_pins.addr   = req.addr;
               nxt_pins.dq_out = req.wdata;
               nxt_pins.ce_n   = 1'b0;
               if (req.kind == FWS_WR) begin
                  nxt_st         = CY_WR;
                  nxt_pins.oe_n  = 1'b1;
                  nxt_pins.we_n  = 1'b0;
                  nxt_pins.dq_oe = 1'b1;
               end else begin
                  nxt_st        = CY_RD;
                  nxt_pins.oe_n = 1'b0;
               end
            end
         end
         CY_RD: begin
            if (cnt_ff == 6'(`FWS_ACC_CYC + `FWS_SYNC_CYC - 1)) begin
               nxt_st = CY_CAP;
            end
         end
         CY_CAP: begin
            // wait for a settled byte, then end the read with the pacing strobe
            if (sync2_ff == sync3_ff) begin
               nxt_rdata = sync3_ff;
               nxt_done  = 1'b1;
               nxt_cnt   = 6'h00;
               nxt_st    = CY_REC;
               if (pace_ce) begin
                  nxt_pins.ce_n = 1'b1;
               end else begin
                  nxt_pins.oe_n = 1'b1;
               end
            end
         end
         CY_WR: begin
            if (cnt_ff == 6'(`FWS_WP_CYC - 1)) begin
               nxt_pins.we_n = 1'b1;     // data latched on this rising edge
               nxt_st        = CY_WH;
            end
         end
         CY_WH: begin
            nxt_pins.ce_n  = 1'b1;
            nxt_pins.dq_oe = 1'b0;
            nxt_done       = 1'b1;
            nxt_cnt        = 6'h00;
            nxt_st         = CY_REC;
         end
         CY_REC: begin
            if (cnt_ff == 6'(`FWS_REC_CYC - 1)) begin
               nxt_st = CY_IDLE;
            end
         end
      endcase
   end

   // cycle sequencer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff    <= CY_IDLE;
         cnt_ff   <= 6'h00;
         pins_ff  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0,
                       dq_out: 8'h00, addr: 21'h000000};
         done_ff  <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         st_ff    <= nxt_st;
         cnt_ff   <= nxt_cnt;
         pins_ff  <= nxt_pins;
         done_ff  <= nxt_done;
         rdata_ff <= nxt_rdata;
      end
   end

   // a read is only taken while both strobes are low
   chk_read_both_low: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff == CY_CAP && sync2_ff == sync3_ff) |-> (!pins_ff.ce_n && !pins_ff.oe_n))
      else $error("read data taken with a strobe high");
endmodule : fws_bus_cycle
`default_nettype wire

// >>> verif/fws_flash_model.sv
// Purpose: behavioural parallel flash that answers status reads
// Assumes: a read ends when chip select or output strobe rises
// Notes:   a released data bus shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module fws_flash_model
   import fws_pkg::*;
(
   // host pins
   input  wire fws_pins_t  pins,
   output logic [7:0]      dq,
   output logic            ready_busy_out_n,
   // scenario set-up
   input  wire logic       op_go,
   input  wire logic [7:0] op_len,
   input  wire logic       op_fail,
   input  wire logic       win,
   input  wire logic       sect_sel,
   input  wire logic [7:0] array_byte,
   // observations
   output int              read_cnt,
   output int              rst_cnt,
   output logic [20:0]     rst_addr
);
   logic       running;
   logic       tog;
   logic       sct;
   logic       lim;
   logic [7:0] val;
   int         left;
   wire logic  rd_act = !pins.ce_n && !pins.oe_n && pins.we_n;

   // idle device at power up
   initial begin
      running = 1'b0;
      lim = 1'b0;
      val = 8'h00;
      rst_cnt = 0;
      rst_addr = 21'h0;
   end
   // status byte while busy, array data otherwise, held through the read
   always @(posedge rd_act) begin
      val = running ? {1'b0, tog, lim, 1'b0, win, sct, 2'b00}
                    : array_byte;
   end
   assign dq = rd_act ? val : ~val;
   assign ready_busy_out_n = !running;
   // either strobe rising ends a read; while busy it flips tog, and sct when sect_sel is set
   always @(negedge rd_act) begin
      read_cnt++;
      if (running) begin
         tog = ~tog;
         sct = sct ^ sect_sel;
         if (left > 1) left--;
         else if (!op_fail) running = 1'b0;
         else lim = 1'b1;
      end
   end
   // reset command ends the operation and clears the failure
   always @(posedge pins.we_n) begin
      if (pins.ce_n === 1'b0 && pins.dq_out === 8'hF0) begin
         rst_cnt++;
         rst_addr = pins.addr;
         running = 1'b0;
         lim = 1'b0;
      end
   end
   // a new internal operation starts
   always @(posedge op_go) begin
      running = 1'b1;
      left = op_len;
      tog = 1'b0;
      sct = 1'b0;
      lim = 1'b0;
      read_cnt = 0;
   end
endmodule : fws_flash_model
`default_nettype wire

// >>> verif/tb_fws_poll_ctrl.sv
// Purpose: self-checking bench of the flash status poller
// Assumes: apb answers after one access cycle
// Notes:   each scenario task drives and judges on its own
`timescale 1ns/1ns
`default_nettype none
`include "fws_params.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_fws_poll_ctrl
   import fws_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, rbn;
   logic        op_go, op_fail, win, sect_sel;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  op_len, array_byte, mdl_dq, dq_in;
   logic [20:0] rst_addr;
   fws_pins_t   pins;
   int          err_count, n_tests, read_cnt, rst_cnt;

   // clock
   always #2 pclk = ~pclk;
   // data wire resolved from the host's enable
   assign dq_in = pins.dq_oe ? pins.dq_out : mdl_dq;

   fws_poll_ctrl fws_poll_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_pins(pins), .flash_dq_in(dq_in),
      .ready_busy_out_n(rbn));
   fws_flash_model fws_flash_model_inst (.pins(pins), .dq(mdl_dq), .ready_busy_out_n(rbn),
      .op_go(op_go), .op_len(op_len), .op_fail(op_fail), .win(win), .sect_sel(sect_sel),
      .array_byte(array_byte), .read_cnt(read_cnt), .rst_cnt(rst_cnt), .rst_addr(rst_addr));

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin err_count++; print_verdict(); end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // poll the busy flag, bounded
   task automatic wait_idle();
      int k;
      for (k = 0; k < 1000; k++) begin
         apb(1'b0, `FWS_REG_STATUS, 32'h0);
         if (rd[`FWS_ST_BUSY] === 1'b0) break;
      end
      if (k == 1000) begin err_count++; print_verdict(); end
   endtask : wait_idle

   // load the device operation and start the poller
   task automatic start_op(input logic [7:0] len, input logic fl, input logic ce,
                           input logic [7:0] arr);
      op_len <= len;
      op_fail <= fl;
      array_byte <= arr;
      sect_sel <= 1'b1;
      op_go <= 1'b1;
      apb(1'b1, `FWS_REG_CTRL, {30'h0, ce, 1'b1});
      op_go <= 1'b0;
   endtask : start_op

   task automatic t_reset();
      apb(1'b0, `FWS_REG_STATUS, 32'h0);
      `CHK(rd[15:0], 16'h0020)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, `FWS_REG_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, `FWS_REG_ADDR, 32'h0);
      `CHK(rd, 32'h001F_FFFF)
   endtask : t_reset

   // chip select paces the reads; four toggling reads, then array data
   task automatic t_ce();
      start_op(8'h04, 1'b0, 1'b1, 8'h0F);
      wait_idle();
      `CHK(rd[2:0], 3'b010)
      `CHK(rd[`FWS_ST_DATA_LSB +: 8], 8'h0F)
      `CHK(read_cnt, 7)
      apb(1'b0, `FWS_REG_CTRL, 32'h0);
      `CHK(rd, 32'h0000_0002)
   endtask : t_ce

   // timing limit reached while still toggling
   task automatic t_fail();
      int n0;
      n0 = rst_cnt;
      apb(1'b1, `FWS_REG_ADDR, 32'h000A_5A5A);
      start_op(8'h02, 1'b1, 1'b0, 8'hC3);
      wait_idle();
      // one more status read so the ready pin has passed its synchroniser
      apb(1'b0, `FWS_REG_STATUS, 32'h0);
      `CHK(rd[2:0], 3'b100)
      `CHK(rd[5:4], 2'b11)
      `CHK(read_cnt, 4)
      `CHK(rst_cnt, n0 + 1)
      `CHK(rst_addr, 21'h0A_5A5A)
   endtask : t_fail

   // leave a long poll, then restart from the top
   task automatic t_stop();
      start_op(8'hC8, 1'b0, 1'b0, 8'h5A);
      apb(1'b0, `FWS_REG_STATUS, 32'h0);
      apb(1'b0, `FWS_REG_STATUS, 32'h0);
      `CHK({rd[`FWS_ST_BUSY], rd[`FWS_ST_READY]}, 2'b10)
      apb(1'b1, `FWS_REG_CTRL, 32'h0000_0004);
      wait_idle();
      `CHK(rd[2:0], 3'b000)
      start_op(8'h03, 1'b0, 1'b0, 8'h5A);
      wait_idle();
      `CHK(rd[4:0], 5'b00010)
      `CHK(rd[`FWS_ST_DATA_LSB +: 8], 8'h5A)
      `CHK(read_cnt, 6)
   endtask : t_stop

   // erase window flag read in both states
   task automatic t_window();
      int w;
      op_len <= 8'hC8;
      op_go <= 1'b1;
      for (w = 0; w < 2; w++) begin
         win <= w[0];
         apb(1'b1, `FWS_REG_CTRL, 32'h0000_0008);
         op_go <= 1'b0;
         wait_idle();
         `CHK({rd[`FWS_ST_WIN_VALID], rd[`FWS_ST_WINDOW]}, {1'b1, w[0]})
      end
   endtask : t_window

   // reset, then the scenarios
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {op_go, op_fail, win, sect_sel, op_len, array_byte} = '0;
      err_count = 0;
      n_tests = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ce();
      t_fail();
      t_stop();
      t_window();
      print_verdict();
   end
endmodule : tb_fws_poll_ctrl
`default_nettype wire
